/* File: crf_map.svh */
// Constant map for the register file and stack top pointer
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_NUM_REGS      32
`define CRF_REG_WIN_LAST  16'h001f
`define CRF_PTR_A_LOW     5'h1a
`define CRF_PTR_B_LOW     5'h1c
`define CRF_PTR_C_LOW     5'h1e
`define CRF_IO_TO_DATA    16'h0020
`define CRF_SP_LOW_IO     6'h3d
`define CRF_SP_HIGH_IO    6'h3e
`define CRF_SP_LOW_DATA   16'h005d
`define CRF_SP_HIGH_DATA  16'h005e
`define CRF_SP_RESET      16'h04ff
`define CRF_SP_WR_MASK    16'h0fff
`endif

/* File: crf_pkg.sv */
// Types shared by the register file design
package crf_pkg;
  typedef enum logic [2:0]
  {
    CRF_SP_HOLD  = 3'b000,
    CRF_SP_PUSH1 = 3'b001,
    CRF_SP_PUSH2 = 3'b011,
    CRF_SP_POP1  = 3'b010,
    CRF_SP_POP2  = 3'b110
  } crf_sp_op_t;
  typedef enum logic [1:0]
  {
    CRF_PTR_DISP = 2'b00,
    CRF_PTR_POST_INC = 2'b01,
    CRF_PTR_PRE_DEC = 2'b11
  } crf_ptr_mode_t;
endpackage

/* File: crf_ptr_unit.sv */
// Pointer address generator for the three indirect pointer modes
`timescale 1ns/100ps
module crf_ptr_unit
  import crf_pkg::*;
(
  // Pointer in
  input  wire logic [15:0]   ptr_value,
  input  wire crf_ptr_mode_t mode,
  input  wire logic [5:0]    disp,
  // Results
  output logic      [15:0]   eff_addr,
  output logic      [15:0]   new_ptr,
  output logic               update
);
  always_comb
  begin
    eff_addr = ptr_value;
    new_ptr = ptr_value;
    update = 1'b0;
    unique case (mode)
      CRF_PTR_DISP:
        eff_addr = ptr_value + {10'h000, disp};
      CRF_PTR_POST_INC:
      begin
        new_ptr = ptr_value + 16'h0001;
        update = 1'b1;
      end
      CRF_PTR_PRE_DEC:
      begin
        eff_addr = ptr_value - 16'h0001;
        new_ptr = ptr_value - 16'h0001;
        update = 1'b1;
      end
      // Unused code acts as a plain access with no pointer change
      default:
        eff_addr = ptr_value;
    endcase
  end
endmodule

/* File: crf_sp_adder.sv */
// Stack top pointer adjustment for push, pop, call and return
`timescale 1ns/100ps
`include "crf_map.svh"
module crf_sp_adder
  import crf_pkg::*;
(
  // Current value and operation
  input  wire logic [15:0] sp_now,
  input  wire crf_sp_op_t  op,
  // Adjusted value
  output logic      [15:0] sp_next
);
  logic [15:0] raw;
  always_comb
  begin
    raw = sp_now;
    unique case (op)
      CRF_SP_HOLD:  raw = sp_now;
      CRF_SP_PUSH1: raw = sp_now - 16'h0001;
      CRF_SP_PUSH2: raw = sp_now - 16'h0002;
      CRF_SP_POP1:  raw = sp_now + 16'h0001;
      CRF_SP_POP2:  raw = sp_now + 16'h0002;
      default:      raw = sp_now;
    endcase
    // Upper bits are not implemented and always read zero
    sp_next = raw & `CRF_SP_WR_MASK;
  end
endmodule

/* File: crf_core_regs.sv */
// Working register file with pointer pairs and stack top pointer
`timescale 1ns/100ps
`include "crf_map.svh"
module crf_core_regs
  import crf_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Operand read ports
  input  wire logic [4:0]    rd_a_sel,
  input  wire logic [4:0]    rd_b_sel,
  output logic      [7:0]    rd_a_data,
  output logic      [7:0]    rd_b_data,
  output logic      [15:0]   rd_word_data,
  // Result write port
  input  wire logic          wr_en,
  input  wire logic          wr_word,
  input  wire logic [4:0]    wr_sel,
  input  wire logic [15:0]   wr_data,
  // Indirect data access
  input  wire logic          ind_en,
  input  wire logic          ind_write,
  input  wire logic [1:0]    ind_ptr_sel,
  input  wire crf_ptr_mode_t ind_mode,
  input  wire logic [5:0]    ind_disp,
  input  wire logic [7:0]    ind_wdata,
  output logic      [15:0]   ind_addr,
  output logic      [7:0]    ind_rdata,
  output logic               ind_hit_regs,
  // Direct data space access
  input  wire logic          dat_en,
  input  wire logic          dat_write,
  input  wire logic [15:0]   dat_addr,
  input  wire logic [7:0]    dat_wdata,
  output logic      [7:0]    dat_rdata,
  output logic               dat_hit,
  // I/O space access
  input  wire logic          io_en,
  input  wire logic          io_write,
  input  wire logic [5:0]    io_addr,
  input  wire logic [7:0]    io_wdata,
  output logic      [7:0]    io_rdata,
  output logic               io_hit,
  // Stack operations
  input  wire crf_sp_op_t    sp_op,
  output logic      [15:0]   stack_top_pointer
);
  logic [7:0]  regs [0:`CRF_NUM_REGS-1];
  logic [15:0] ptr_value;
  logic [15:0] ind_new_ptr;
  logic        ind_update;
  logic [15:0] sp_adjusted;
  logic        sp_low_wr;
  logic        sp_high_wr;
  logic [7:0]  sp_wr_byte;
  logic [4:0]  ptr_low_idx;
  logic        dat_reg_hit;
  logic        dat_sp_low;
  logic        dat_sp_high;
  logic        io_sp_low;
  logic        io_sp_high;
  logic [15:0] next_stack_top;

  // Pointer pair selection
  always_comb
  begin
    unique case (ind_ptr_sel)
      2'd0:    ptr_low_idx = `CRF_PTR_A_LOW;
      2'd1:    ptr_low_idx = `CRF_PTR_B_LOW;
      default: ptr_low_idx = `CRF_PTR_C_LOW;
    endcase
  end
  assign ptr_value = {regs[ptr_low_idx + 5'd1], regs[ptr_low_idx]};

  crf_ptr_unit u_ptr
  (
    .ptr_value (ptr_value),
    .mode      (ind_mode),
    .disp      (ind_disp),
    .eff_addr  (ind_addr),
    .new_ptr   (ind_new_ptr),
    .update    (ind_update)
  );

  crf_sp_adder u_sp
  (
    .sp_now  (stack_top_pointer),
    .op      (sp_op),
    .sp_next (sp_adjusted)
  );

  // Address decode
  assign ind_hit_regs = ind_en && (ind_addr <= `CRF_REG_WIN_LAST);
  assign dat_reg_hit = dat_addr <= `CRF_REG_WIN_LAST;
  assign dat_sp_low = dat_addr == `CRF_SP_LOW_DATA;
  assign dat_sp_high = dat_addr == `CRF_SP_HIGH_DATA;
  assign io_sp_low = io_addr == `CRF_SP_LOW_IO;
  assign io_sp_high = io_addr == `CRF_SP_HIGH_IO;
  assign dat_hit = dat_en && (dat_reg_hit || dat_sp_low || dat_sp_high);
  assign io_hit = io_en && (io_sp_low || io_sp_high);

  // Combinational reads keep operand fetch and write-back in one cycle
  assign rd_a_data = regs[rd_a_sel];
  assign rd_b_data = regs[rd_b_sel];
  assign rd_word_data = {regs[{rd_a_sel[4:1], 1'b1}], regs[{rd_a_sel[4:1], 1'b0}]};
  assign ind_rdata = ind_hit_regs ? regs[ind_addr[4:0]] : 8'h00;

  always_comb
  begin
    dat_rdata = 8'h00;
    if (dat_en && dat_reg_hit)
      dat_rdata = regs[dat_addr[4:0]];
    else if (dat_en && dat_sp_low)
      dat_rdata = stack_top_pointer[7:0];
    else if (dat_en && dat_sp_high)
      dat_rdata = stack_top_pointer[15:8];
  end

  always_comb
  begin
    io_rdata = 8'h00;
    if (io_en && io_sp_low)
      io_rdata = stack_top_pointer[7:0];
    else if (io_en && io_sp_high)
      io_rdata = stack_top_pointer[15:8];
  end

  // Register file writes; later statements take priority when ports collide:
  // result port, then pointer update, then direct and indirect stores.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `CRF_NUM_REGS; i++)
        regs[i] <= 8'h00;
    end
    else
    begin
      if (wr_en && wr_word)
      begin
        regs[{wr_sel[4:1], 1'b0}] <= wr_data[7:0];
        regs[{wr_sel[4:1], 1'b1}] <= wr_data[15:8];
      end
      else if (wr_en)
        regs[wr_sel] <= wr_data[7:0];
      if (ind_en && ind_update)
      begin
        regs[ptr_low_idx] <= ind_new_ptr[7:0];
        regs[ptr_low_idx + 5'd1] <= ind_new_ptr[15:8];
      end
      if (dat_en && dat_write && dat_reg_hit)
        regs[dat_addr[4:0]] <= dat_wdata;
      if (ind_hit_regs && ind_write)
        regs[ind_addr[4:0]] <= ind_wdata;
    end
  end

  // Stack top pointer: software byte writes override hardware adjustment
  assign sp_low_wr = (io_en && io_write && io_sp_low) || (dat_en && dat_write && dat_sp_low);
  assign sp_high_wr = (io_en && io_write && io_sp_high) || (dat_en && dat_write && dat_sp_high);
  assign sp_wr_byte = (io_en && io_write) ? io_wdata : dat_wdata;

  always_comb
  begin
    next_stack_top = sp_adjusted;
    if (sp_low_wr)
      next_stack_top[7:0] = sp_wr_byte;
    if (sp_high_wr)
      next_stack_top[15:8] = sp_wr_byte;
    next_stack_top = next_stack_top & `CRF_SP_WR_MASK;
  end

  // Clocked straight from the core clock, no divider
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stack_top_pointer <= `CRF_SP_RESET;
    else
      stack_top_pointer <= next_stack_top;
  end

  // Checks
  sequence s_push2;
    sp_op == CRF_SP_PUSH2 && !sp_low_wr && !sp_high_wr;
  endsequence
  sequence s_pop2;
    sp_op == CRF_SP_POP2 && !sp_low_wr && !sp_high_wr;
  endsequence

  property p_sp_push1;
    @(posedge clock) disable iff (rst)
      (sp_op == CRF_SP_PUSH1 && !sp_low_wr && !sp_high_wr) |=>
        stack_top_pointer == (($past(stack_top_pointer) - 16'h0001) & 16'h0fff);
  endproperty
  a_sp_push1: assert property (p_sp_push1) else $error("push did not subtract one");

  property p_sp_pop1;
    @(posedge clock) disable iff (rst)
      (sp_op == CRF_SP_POP1 && !sp_low_wr && !sp_high_wr) |=>
        stack_top_pointer == (($past(stack_top_pointer) + 16'h0001) & 16'h0fff);
  endproperty
  a_sp_pop1: assert property (p_sp_pop1) else $error("pop did not add one");

  property p_sp_call;
    @(posedge clock) disable iff (rst)
      s_push2 |=> stack_top_pointer == (($past(stack_top_pointer) - 16'h0002) & 16'h0fff);
  endproperty
  a_sp_call: assert property (p_sp_call) else $error("call did not subtract two");

  property p_sp_ret;
    @(posedge clock) disable iff (rst)
      s_pop2 |=> stack_top_pointer == (($past(stack_top_pointer) + 16'h0002) & 16'h0fff);
  endproperty
  a_sp_ret: assert property (p_sp_ret) else $error("return did not add two");

  property p_sp_high_zero;
    @(posedge clock) disable iff (rst) stack_top_pointer[15:12] == 4'h0;
  endproperty
  a_sp_high_zero: assert property (p_sp_high_zero) else $error("stack bits 15:12 set");

  property p_sp_reset;
    @(posedge clock) $fell(rst) |-> stack_top_pointer == 16'h04ff;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack reset value wrong");

  property p_io_sp_read;
    @(posedge clock) disable iff (rst)
      (io_en && io_addr == 6'h3d) |-> io_rdata == stack_top_pointer[7:0] && io_hit;
  endproperty
  a_io_sp_read: assert property (p_io_sp_read) else $error("I/O stack low read wrong");

  property p_dat_sp_alias;
    @(posedge clock) disable iff (rst)
      (dat_en && dat_addr == 16'h005e) |-> dat_rdata == stack_top_pointer[15:8];
  endproperty
  a_dat_sp_alias: assert property (p_dat_sp_alias) else $error("data stack high read wrong");

  property p_word_write;
    @(posedge clock) disable iff (rst)
      (wr_en && wr_word && !ind_en && !dat_en) |=>
        rd_word_data == $past(wr_data) || rd_a_sel[4:1] != $past(wr_sel[4:1]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write lost");

  property p_byte_write;
    @(posedge clock) disable iff (rst)
      (wr_en && !wr_word && !ind_en && !dat_en) |=>
        regs[$past(wr_sel)] == $past(wr_data[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost");

  property p_postinc;
    @(posedge clock) disable iff (rst)
      (ind_en && ind_mode == CRF_PTR_POST_INC && !wr_en && !dat_en && !ind_write) |=>
        ptr_value == $past(ptr_value) + 16'h0001 || ind_ptr_sel != $past(ind_ptr_sel);
  endproperty
  a_postinc: assert property (p_postinc) else $error("pointer not incremented");

  // A pair write is judged on the array itself, so a later operand select cannot hide it
  sequence s_pair_write;
    wr_en && wr_word && !ind_en && !dat_en;
  endsequence

  property p_pair_landed;
    @(posedge clock) disable iff (rst)
      s_pair_write |=>
        {regs[{$past(wr_sel[4:1]), 1'b1}], regs[{$past(wr_sel[4:1]), 1'b0}]} == $past(wr_data);
  endproperty
  a_pair_landed: assert property (p_pair_landed) else $error("pair write not stored");

  property p_predec_addr;
    @(posedge clock) disable iff (rst)
      (ind_en && ind_mode == CRF_PTR_PRE_DEC) |-> ind_addr == ptr_value - 16'h0001;
  endproperty
  a_predec_addr: assert property (p_predec_addr) else $error("pre-decrement address wrong");

  property p_disp_addr;
    @(posedge clock) disable iff (rst)
      (ind_en && ind_mode == CRF_PTR_DISP) |-> ind_addr == ptr_value + {10'h000, ind_disp};
  endproperty
  a_disp_addr: assert property (p_disp_addr) else $error("displacement address wrong");

  property p_ind_window;
    @(posedge clock) disable iff (rst)
      (ind_en && ind_addr <= 16'h001f) |-> ind_hit_regs && ind_rdata == regs[ind_addr[4:0]];
  endproperty
  a_ind_window: assert property (p_ind_window) else $error("indirect window read wrong");

  property p_dat_window;
    @(posedge clock) disable iff (rst)
      (dat_en && dat_addr <= 16'h001f) |-> dat_hit && dat_rdata == regs[dat_addr[4:0]];
  endproperty
  a_dat_window: assert property (p_dat_window) else $error("data window read wrong");

  // Stray reads above the stack bytes must stay harmless
  property p_dat_miss;
    @(posedge clock) disable iff (rst)
      (dat_en && dat_addr > 16'h005e) |-> !dat_hit && dat_rdata == 8'h00;
  endproperty
  a_dat_miss: assert property (p_dat_miss) else $error("unmapped data read not zero");

  // Software byte writes with no stack adjustment in the same cycle
  sequence s_sw_low_data;
    dat_en && dat_write && dat_addr == 16'h005d && !io_en && sp_op == CRF_SP_HOLD;
  endsequence
  sequence s_sw_high_io;
    io_en && io_write && io_addr == 6'h3e && !dat_en && sp_op == CRF_SP_HOLD;
  endsequence

  property p_sw_low;
    @(posedge clock) disable iff (rst)
      s_sw_low_data |=> stack_top_pointer[7:0] == $past(dat_wdata);
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("stack low byte write lost");

  property p_sw_high;
    @(posedge clock) disable iff (rst)
      s_sw_high_io |=> stack_top_pointer[15:8] == ($past(io_wdata) & 8'h0f);
  endproperty
  a_sw_high: assert property (p_sw_high) else $error("stack high byte write lost");
endmodule

/* File: crf_dec_model.sv */
// Decoder-side request model that drives the register file ports
`timescale 1ns/100ps
module crf_dec_model
  import crf_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Requests toward the register file
  output logic      [4:0]  rd_a_sel,
  output logic      [4:0]  rd_b_sel,
  output logic             wr_en,
  output logic             wr_word,
  output logic      [4:0]  wr_sel,
  output logic      [15:0] wr_data,
  output logic             ind_en,
  output logic             ind_write,
  output logic      [1:0]  ind_ptr_sel,
  output crf_ptr_mode_t    ind_mode,
  output logic      [5:0]  ind_disp,
  output logic      [7:0]  ind_wdata,
  output logic             dat_en,
  output logic             dat_write,
  output logic      [15:0] dat_addr,
  output logic      [7:0]  dat_wdata,
  output logic             io_en,
  output logic             io_write,
  output logic      [5:0]  io_addr,
  output logic      [7:0]  io_wdata,
  output crf_sp_op_t       sp_op
);
  initial
  begin
    {rd_a_sel, rd_b_sel, wr_en, wr_word, wr_sel, wr_data, ind_en, ind_write, ind_ptr_sel,
     ind_disp, ind_wdata, dat_en, dat_write, dat_addr, dat_wdata, io_en, io_write, io_addr,
     io_wdata} = '0;
    ind_mode = CRF_PTR_DISP;
    sp_op = CRF_SP_HOLD;
  end
  // Kinds: 0 none, 1 byte write, 2 pair write, 3/4 indirect read/write,
  // 5/6 data read/write, 7/8 I/O read/write; every port is set once per call
  // so back-to-back calls never assign a signal twice in one time step
  task automatic drive(input int k, input logic [15:0] a = '0, input logic [15:0] d = '0,
    input logic [1:0] p = '0, input crf_ptr_mode_t m = CRF_PTR_DISP,
    input logic [5:0] disp = '0, input crf_sp_op_t s = CRF_SP_HOLD);
    @(posedge clock);
    rd_a_sel <= a[4:0];
    rd_b_sel <= a[4:0] ^ 5'h01;
    wr_en <= k == 1 || k == 2;
    wr_word <= k == 2;
    wr_sel <= a[4:0];
    wr_data <= d;
    ind_en <= k == 3 || k == 4;
    ind_write <= k == 4;
    ind_ptr_sel <= p;
    ind_mode <= m;
    ind_disp <= disp;
    ind_wdata <= d[7:0];
    dat_en <= k == 5 || k == 6;
    dat_write <= k == 6;
    dat_addr <= a;
    dat_wdata <= d[7:0];
    io_en <= k == 7 || k == 8;
    io_write <= k == 8;
    io_addr <= a[5:0];
    io_wdata <= d[7:0];
    sp_op <= s;
    // Outputs are looked at mid-cycle, after the edge's updates have landed
    @(negedge clock);
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench for the working register file
`timescale 1ns/100ps
module tb;
  import crf_pkg::*;
  logic                clock;
  logic                rst;
  logic [4:0]          rd_a_sel, rd_b_sel, wr_sel;
  logic [7:0]          rd_a_data, rd_b_data, ind_wdata, ind_rdata, dat_wdata, dat_rdata;
  logic [7:0]          io_wdata, io_rdata;
  logic [15:0]         rd_word_data, wr_data, ind_addr, dat_addr, stack_top_pointer;
  logic                wr_en, wr_word, ind_en, ind_write, ind_hit_regs;
  logic                dat_en, dat_write, dat_hit, io_en, io_write, io_hit;
  logic [1:0]          ind_ptr_sel;
  logic [5:0]          ind_disp, io_addr;
  crf_ptr_mode_t       ind_mode;
  crf_sp_op_t          sp_op;
  int                  n_errors;
  int                  total_checks;
  logic [15:0]         e;
  crf_sp_op_t          ops [4] = '{CRF_SP_PUSH1, CRF_SP_PUSH2, CRF_SP_POP1, CRF_SP_POP2};
  logic [15:0]         dl [4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};

  crf_core_regs i_dut (.clock, .rst, .rd_a_sel, .rd_b_sel, .rd_a_data, .rd_b_data,
    .rd_word_data, .wr_en, .wr_word, .wr_sel, .wr_data, .ind_en, .ind_write, .ind_ptr_sel,
    .ind_mode, .ind_disp, .ind_wdata, .ind_addr, .ind_rdata, .ind_hit_regs, .dat_en,
    .dat_write, .dat_addr, .dat_wdata, .dat_rdata, .dat_hit, .io_en, .io_write, .io_addr,
    .io_wdata, .io_rdata, .io_hit, .sp_op, .stack_top_pointer);
  crf_dec_model i_dec (.clock, .rd_a_sel, .rd_b_sel, .wr_en, .wr_word, .wr_sel, .wr_data,
    .ind_en, .ind_write, .ind_ptr_sel, .ind_mode, .ind_disp, .ind_wdata, .dat_en,
    .dat_write, .dat_addr, .dat_wdata, .io_en, .io_write, .io_addr, .io_wdata, .sp_op);

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Nothing here waits on a handshake, so one overall limit cuts any hang short
  initial
  begin
    #2000000;
    n_errors++;
    $display("BAD %0t run limit reached", $time);
    print_verdict();
  end

  initial
  begin
    n_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    i_dec.drive(7, 16'h003d);
    chk(stack_top_pointer, 16'h04ff);
    chk(16'(io_rdata), 16'h00ff);
    chk(16'(io_hit), 16'h0001);
    i_dec.drive(7, 16'h003e);
    chk(16'(io_rdata), 16'h0004);
    i_dec.drive(7, 16'h003f);
    chk({7'd0, io_hit, io_rdata}, 16'h0000);
    i_dec.drive(5, 16'h005e);
    chk(16'(dat_rdata), 16'h0004);
    // Fill every register back to back, then read through both paths
    for (int i = 0; i < 32; i++)
      i_dec.drive(1, 16'(i), 16'(i * 3 + 1));
    for (int i = 0; i < 32; i++)
    begin
      i_dec.drive(5, 16'(i));
      chk(16'(dat_rdata), 16'(8'(i * 3 + 1)));
      chk(16'(rd_a_data), 16'(8'(i * 3 + 1)));
      chk(16'(rd_b_data), 16'(8'((i ^ 1) * 3 + 1)));
    end
    i_dec.drive(2, 16'd26, 16'h1234);
    i_dec.drive(0, 16'd26);
    chk(rd_word_data, 16'h1234);
    chk({rd_b_data, rd_a_data}, 16'h1234);
    i_dec.drive(2, 16'd26, 16'h0005);
    i_dec.drive(2, 16'd28, 16'h0010);
    i_dec.drive(2, 16'd30, 16'h0002);
    i_dec.drive(3, 16'd0, 16'd0, 2'd0, CRF_PTR_POST_INC);
    chk(ind_addr, 16'h0005);
    chk({7'd0, ind_hit_regs, ind_rdata}, 16'h0110);
    i_dec.drive(3, 16'd26, 16'd0, 2'd1, CRF_PTR_PRE_DEC);
    chk(rd_word_data, 16'h0006);
    chk(ind_addr, 16'h000f);
    chk(16'(ind_rdata), 16'h002e);
    i_dec.drive(4, 16'd28, 16'h00a5, 2'd2, CRF_PTR_DISP, 6'd3);
    chk(rd_word_data, 16'h000f);
    chk(ind_addr, 16'h0005);
    i_dec.drive(0, 16'd5);
    chk(16'(rd_a_data), 16'h00a5);
    i_dec.drive(5, 16'd30);
    chk(rd_word_data, 16'h0002);
    i_dec.drive(5, 16'h0060);
    chk({7'd0, dat_hit, dat_rdata}, 16'h0000);
    // Software places the stack before any call; high nibble must stay zero
    i_dec.drive(8, 16'h003e, 16'h00ff);
    i_dec.drive(6, 16'h005d, 16'h0020);
    i_dec.drive(0);
    chk(stack_top_pointer, 16'h0f20);
    e = 16'h0f20;
    for (int i = 0; i < 4; i++)
    begin
      i_dec.drive(0, .s(ops[i]));
      i_dec.drive(0);
      e = e + dl[i];
      chk(stack_top_pointer, e);
    end
    print_verdict();
  end
endmodule
